// ---- design/cdiag_pkg.sv ----
// Constants, types and helpers of the cable diagnostic result register bank.
// Assumes a 32-bit AXI4-Lite slave where each register index is one aligned word.
package cdiag_pkg;

  // ----------------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int IDX_W = 16;
  localparam int PAIRS = 3;
  localparam int WORD_W = 11;

  // ----------------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ----------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_RUN = 16'hBA1B;
  localparam logic [IDX_W-1:0] IDX_XPAIR = 16'hBA1C;
  localparam logic [IDX_W-1:0] IDX_RESULT0 = 16'hBA1D;
  localparam logic [IDX_W-1:0] IDX_RESULT1 = 16'hBA1E;
  localparam logic [IDX_W-1:0] IDX_RESULT2 = 16'hBA1F;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 16'hBA30;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 16'hBA31;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int BIT_RUN = 0;
  localparam int BIT_XPAIR_OFF = 0;
  localparam int BIT_FOREIGN = 10;
  localparam int BIT_MISMATCH = 6;
  localparam int BIT_SHORT = 2;
  localparam int BIT_OPEN = 1;
  localparam int BIT_GOOD = 0;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_W = 2;

  // Cross-short flags: bits 9..7 significant impedance, bits 5..3 plain short.
  localparam logic [WORD_W-1:0] CROSS_MASK = 11'h3B8;
  // Every flag that reports a fault, that is everything except good termination.
  localparam logic [WORD_W-1:0] FAULT_MASK = 11'h7FE;

  // ----------------------------------------------------------------------
  // Reset values and bus answers
  // ----------------------------------------------------------------------
  localparam logic RUN_RST = 1'b0;
  localparam logic XPAIR_RST = 1'b0;
  localparam logic [WORD_W-1:0] RESULT_RST = 11'h000;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef logic [WORD_W-1:0] pair_word_t;
  typedef logic [PAIRS-1:0][WORD_W-1:0] result_set_t;
  typedef enum logic {ENG_IDLE, ENG_MEASURE} eng_state_t;

  // Removes the cross-pair flags when cross-pair checking is turned off.
  function automatic pair_word_t gate_cross(input pair_word_t w, input logic off);
    gate_cross = off ? (w & ~CROSS_MASK) : w;
  endfunction

  // Word index of a byte address.
  function automatic logic [IDX_W-1:0] byte_to_index(input logic [ADDR_W-1:0] a);
    byte_to_index = a[ADDR_W-1:2];
  endfunction

endpackage

// ---- design/regbus_if.sv ----
// Register access interface between the bus slave and the register file.
// Assumes one clock; all signals are meaningful in the cycle they are driven.
`timescale 1ns/10ps
interface regbus_if;
  import cdiag_pkg::*;
  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;
  logic [IDX_W-1:0] rd_idx;
  logic [DATA_W-1:0] rd_data;
  logic rd_hit;

  modport slave (output wr_en, wr_idx, wr_data, wr_strb, rd_idx,
                 input wr_hit, rd_data, rd_hit);
  modport regs (input wr_en, wr_idx, wr_data, wr_strb, rd_idx,
                output wr_hit, rd_data, rd_hit);
endinterface

// ---- design/axil_slave.sv ----
// AXI4-Lite slave that turns bus transfers into single-cycle register accesses.
// Assumes the register file answers decode and read data combinationally.
`timescale 1ns/10ps
module axil_slave
  import cdiag_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  regbus_if.slave rb
);
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [IDX_W-1:0] aw_idx, next_aw_idx;
  logic [DATA_W-1:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [DATA_W-1:0] next_rdata;

  // ----------------------------------------------------------------------
  // Address and data are held apart, so they may arrive in either order
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_idx = aw_idx;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    rb.wr_en = aw_held && w_held && !bvalid;
    rb.wr_idx = aw_idx;
    rb.wr_data = w_data;
    rb.wr_strb = w_strb;
    rb.rd_idx = byte_to_index(araddr);
    if (awvalid && awready)
    begin
      next_aw_held = 1'b1;
      next_aw_idx = byte_to_index(awaddr);
    end
    if (wvalid && wready)
    begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (bvalid && bready)
      next_bvalid = 1'b0;
    if (rb.wr_en)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = rb.wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid && rready)
      next_rvalid = 1'b0;
    if (arvalid && arready)
    begin
      next_rvalid = 1'b1;
      next_rdata = rb.rd_data;
      next_rresp = rb.rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held <= 1'b0;
      aw_idx <= '0;
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end
    else
    begin
      aw_held <= next_aw_held;
      aw_idx <= next_aw_idx;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end
endmodule

// ---- design/diag_engine.sv ----
// Diagnostic run sequencer: starts a measurement and posts the per-pair flags.
// Assumes the analog front end answers each start with one done pulse and flags.
`timescale 1ns/10ps
module diag_engine
  import cdiag_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run_req,
  input wire logic xpair_off,
  output logic meas_start,
  input wire logic meas_done,
  input wire result_set_t meas_flags,
  output logic busy,
  output logic done,
  output logic fault,
  output logic xoff_run,
  output result_set_t result
);
  eng_state_t state, next_state;
  logic next_meas_start, next_done, next_fault, next_xoff_run;
  result_set_t next_result;

  always_comb
  begin
    next_state = state;
    next_meas_start = 1'b0;
    next_done = 1'b0;
    next_fault = 1'b0;
    next_xoff_run = xoff_run;
    next_result = result;
    case (state)
      ENG_IDLE:
      begin
        // The done guard keeps the still-set run bit from restarting a run.
        if (run_req && !done)
        begin
          next_state = ENG_MEASURE;
          next_meas_start = 1'b1;
          next_xoff_run = xpair_off;
          for (int p = 0; p < PAIRS; p++)
            next_result[p] = RESULT_RST;
        end
      end
      ENG_MEASURE:
      begin
        if (meas_done)
        begin
          next_state = ENG_IDLE;
          next_done = 1'b1;
          for (int p = 0; p < PAIRS; p++)
          begin
            next_result[p] = gate_cross(meas_flags[p], xoff_run);
            if ((next_result[p] & FAULT_MASK) != RESULT_RST)
              next_fault = 1'b1;
          end
        end
      end
      default:
        next_state = ENG_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ENG_IDLE;
      meas_start <= 1'b0;
      done <= 1'b0;
      fault <= 1'b0;
      xoff_run <= XPAIR_RST;
      result <= '0;
      busy <= 1'b0;
    end
    else
    begin
      state <= next_state;
      meas_start <= next_meas_start;
      done <= next_done;
      fault <= next_fault;
      xoff_run <= next_xoff_run;
      result <= next_result;
      busy <= (next_state == ENG_MEASURE);
    end
  end
endmodule

// ---- design/cable_diag_result_regs.sv ----
// Top of the cable diagnostic result register bank with its run control.
// Assumes an AXI4-Lite master and an analog front end that reports per-pair flags.
`timescale 1ns/10ps

// Behaviour
// - Cross-pair off bit suppresses cross checks next run.
// - Cross-pair off bit resets to zero; upper bits zero.
// - Bit 10 flags foreign activity, pair busy.
// - Pair 0 bits 9/8/7 high-impedance toward 3/2/1.
// - Bit 6 flags significant impedance mismatch.
// - Pair 0 bits 5/4/3 cross short toward 3/2/1.
// - Bit 2 flags a short on the pair.
// - Bit 1 flags an open on the pair.
// - Bit 0 flags good termination.
// - Pair 1 cross bits name pairs 3, 2, 0.
// - Pair 2 cross bits name pairs 3, 1, 0.
// - Result words read only, reset zero, bits 15-11 zero.
// - Run bit starts a run and self-clears when done.
module cable_diag_result_regs
  import cdiag_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [cdiag_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [cdiag_pkg::DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [cdiag_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [cdiag_pkg::DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic MEAS_START,
  input wire logic MEAS_DONE,
  input wire cdiag_pkg::result_set_t MEAS_FLAGS,
  output logic IRQ
);
  import cdiag_pkg::*;

  regbus_if rb ();

  logic run_bit, next_run_bit;
  logic xpair_off, next_xpair_off;
  logic [IRQ_W-1:0] irq_status, next_irq_status;
  logic [IRQ_W-1:0] irq_mask, next_irq_mask;
  logic next_irq;
  logic eng_busy, eng_done, eng_fault, eng_xoff;
  result_set_t eng_result;
  logic wr_lane0;
  logic [IRQ_W-1:0] irq_events;

  // ----------------------------------------------------------------------
  // Bus slave and diagnostic sequencer
  // ----------------------------------------------------------------------
  axil_slave i_axil_slave (
    .clk(MCLK),
    .rst_n(RST_N),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .awaddr(S_AXI_AWADDR),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .bvalid(S_AXI_BVALID),
    .bready(S_AXI_BREADY),
    .bresp(S_AXI_BRESP),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .araddr(S_AXI_ARADDR),
    .rvalid(S_AXI_RVALID),
    .rready(S_AXI_RREADY),
    .rdata(S_AXI_RDATA),
    .rresp(S_AXI_RRESP),
    .rb(rb.slave)
  );

  diag_engine i_diag_engine (
    .clk(MCLK),
    .rst_n(RST_N),
    .run_req(run_bit),
    .xpair_off(xpair_off),
    .meas_start(MEAS_START),
    .meas_done(MEAS_DONE),
    .meas_flags(MEAS_FLAGS),
    .busy(eng_busy),
    .done(eng_done),
    .fault(eng_fault),
    .xoff_run(eng_xoff),
    .result(eng_result)
  );

  // ----------------------------------------------------------------------
  // Register writes, run control and interrupt status
  // ----------------------------------------------------------------------
  assign wr_lane0 = rb.wr_en && rb.wr_strb[0];
  assign irq_events = {eng_done && eng_fault, eng_done};

  always_comb
  begin
    next_run_bit = run_bit;
    next_xpair_off = xpair_off;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    rb.wr_hit = 1'b0;
    case (rb.wr_idx)
      IDX_RUN, IDX_XPAIR, IDX_RESULT0, IDX_RESULT1, IDX_RESULT2,
      IDX_IRQ_STATUS, IDX_IRQ_MASK:
        rb.wr_hit = 1'b1;
      default:
        rb.wr_hit = 1'b0;
    endcase
    // A written one starts a run; zeros are ignored so a run is never cut short.
    if (wr_lane0 && rb.wr_idx == IDX_RUN && rb.wr_data[BIT_RUN])
      next_run_bit = 1'b1;
    if (eng_done)
      next_run_bit = 1'b0;
    if (wr_lane0 && rb.wr_idx == IDX_XPAIR)
      next_xpair_off = rb.wr_data[BIT_XPAIR_OFF];
    if (wr_lane0 && rb.wr_idx == IDX_IRQ_MASK)
      next_irq_mask = rb.wr_data[IRQ_W-1:0];
    if (wr_lane0 && rb.wr_idx == IDX_IRQ_STATUS)
      next_irq_status = irq_status & ~rb.wr_data[IRQ_W-1:0];
    // A new event wins over a clear in the same cycle.
    next_irq_status = next_irq_status | irq_events;
    next_irq = |(next_irq_status & next_irq_mask);
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      run_bit <= RUN_RST;
      xpair_off <= XPAIR_RST;
      irq_status <= IRQ_RST;
      irq_mask <= IRQ_RST;
      IRQ <= 1'b0;
    end
    else
    begin
      run_bit <= next_run_bit;
      xpair_off <= next_xpair_off;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      IRQ <= next_irq;
    end
  end

  // ----------------------------------------------------------------------
  // Read decode; results are read only and unused bits read as zero
  // ----------------------------------------------------------------------
  always_comb
  begin
    rb.rd_data = '0;
    rb.rd_hit = 1'b1;
    case (rb.rd_idx)
      IDX_RUN: rb.rd_data[BIT_RUN] = run_bit;
      IDX_XPAIR: rb.rd_data[BIT_XPAIR_OFF] = xpair_off;
      IDX_RESULT0: rb.rd_data[WORD_W-1:0] = eng_result[0];
      IDX_RESULT1: rb.rd_data[WORD_W-1:0] = eng_result[1];
      IDX_RESULT2: rb.rd_data[WORD_W-1:0] = eng_result[2];
      IDX_IRQ_STATUS: rb.rd_data[IRQ_W-1:0] = irq_status;
      IDX_IRQ_MASK: rb.rd_data[IRQ_W-1:0] = irq_mask;
      default: rb.rd_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  logic capture;
  logic out_of_reset;
  assign capture = eng_busy && MEAS_DONE;

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      out_of_reset <= 1'b0;
    else
      out_of_reset <= 1'b1;
  end

  property p_xpair_gate;
    @(posedge MCLK) disable iff (!RST_N)
      capture && eng_xoff |=> (eng_result[0] & CROSS_MASK) == RESULT_RST
        && (eng_result[1] & CROSS_MASK) == RESULT_RST
        && (eng_result[2] & CROSS_MASK) == RESULT_RST;
  endproperty
  a_xpair_gate: assert property (p_xpair_gate)
    else $error("Cross-pair flag posted while checking was off.");

  property p_reset_zero;
    @(posedge MCLK) disable iff (!RST_N)
      !out_of_reset |-> !xpair_off && !run_bit && eng_result == '0;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("Control or result not zero after reset.");

  property p_flag_bit(int b);
    @(posedge MCLK) disable iff (!RST_N)
      capture |=> eng_result[0][b] == $past(MEAS_FLAGS[0][b])
        && eng_result[1][b] == $past(MEAS_FLAGS[1][b])
        && eng_result[2][b] == $past(MEAS_FLAGS[2][b]);
  endproperty
  a_foreign: assert property (p_flag_bit(BIT_FOREIGN))
    else $error("Foreign activity flag not posted.");
  a_mismatch: assert property (p_flag_bit(BIT_MISMATCH))
    else $error("Impedance mismatch flag not posted.");
  a_short: assert property (p_flag_bit(BIT_SHORT))
    else $error("Short flag not posted.");
  a_open: assert property (p_flag_bit(BIT_OPEN))
    else $error("Open flag not posted.");
  a_good: assert property (p_flag_bit(BIT_GOOD))
    else $error("Good termination flag not posted.");

  property p_cross_pair(int p);
    @(posedge MCLK) disable iff (!RST_N)
      capture && !eng_xoff |=> (eng_result[p] & CROSS_MASK)
        == ($past(MEAS_FLAGS[p]) & CROSS_MASK);
  endproperty
  a_cross_p0: assert property (p_cross_pair(0))
    else $error("Pair 0 cross flags misplaced.");
  a_cross_p1: assert property (p_cross_pair(1))
    else $error("Pair 1 cross flags misplaced.");
  a_cross_p2: assert property (p_cross_pair(2))
    else $error("Pair 2 cross flags misplaced.");

  property p_result_read;
    @(posedge MCLK) disable iff (!RST_N)
      S_AXI_ARVALID && S_AXI_ARREADY && rb.rd_idx == IDX_RESULT0
        |=> S_AXI_RVALID && S_AXI_RDATA[DATA_W-1:WORD_W] == '0
          && S_AXI_RDATA[WORD_W-1:0] == $past(eng_result[0]);
  endproperty
  a_result_read: assert property (p_result_read)
    else $error("Result word read back wrong.");

  property p_run_start;
    @(posedge MCLK) disable iff (!RST_N)
      $rose(run_bit) |=> MEAS_START ##1 !MEAS_START;
  endproperty
  a_run_start: assert property (p_run_start)
    else $error("Run bit did not start one measurement.");

  property p_run_clear;
    @(posedge MCLK) disable iff (!RST_N)
      capture |=> eng_done ##1 !run_bit && !eng_busy;
  endproperty
  a_run_clear: assert property (p_run_clear)
    else $error("Run bit did not self-clear after the run.");

  property p_start_clear;
    @(posedge MCLK) disable iff (!RST_N)
      MEAS_START |-> eng_result == '0 && eng_busy;
  endproperty
  a_start_clear: assert property (p_start_clear)
    else $error("Results not cleared at run start.");

  property p_irq_level;
    @(posedge MCLK) disable iff (!RST_N)
      eng_done |=> irq_status[IRQ_DONE] && (IRQ == irq_mask[IRQ_DONE] || IRQ);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("Run completion did not reach the interrupt.");

  property p_irq_out;
    @(posedge MCLK) disable iff (!RST_N)
      IRQ == |(irq_status & irq_mask);
  endproperty
  a_irq_out: assert property (p_irq_out)
    else $error("Interrupt output does not follow status and mask.");

  property p_xpair_read;
    @(posedge MCLK) disable iff (!RST_N)
      S_AXI_ARVALID && S_AXI_ARREADY && rb.rd_idx == IDX_XPAIR
        |=> S_AXI_RDATA[DATA_W-1:1] == '0 && S_AXI_RDATA[0] == $past(xpair_off);
  endproperty
  a_xpair_read: assert property (p_xpair_read)
    else $error("Cross-pair control read back wrong.");

  property p_run_hold;
    @(posedge MCLK) disable iff (!RST_N)
      eng_busy |-> run_bit;
  endproperty
  a_run_hold: assert property (p_run_hold)
    else $error("Run bit cleared while a run was busy.");

  property p_result_hold;
    @(posedge MCLK) disable iff (!RST_N)
      !eng_busy |=> $stable(eng_result) || MEAS_START;
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("Results changed outside a run.");

  c_run: cover property (@(posedge MCLK) disable iff (!RST_N) eng_done);
  c_xoff_run: cover property (@(posedge MCLK) disable iff (!RST_N) capture && eng_xoff);
  c_fault_irq: cover property (@(posedge MCLK) disable iff (!RST_N)
    irq_status[IRQ_FAULT] && IRQ);
  c_stray: cover property (@(posedge MCLK) disable iff (!RST_N) MEAS_DONE && !eng_busy);
  c_irq_clear: cover property (@(posedge MCLK) disable iff (!RST_N) IRQ ##1 !IRQ);
endmodule

// ---- verif/cable_model.sv ----
// Behavioural cable and front end that answers each measurement start.
// Assumes the bench picks the answer delay and the per-pair flags.
`timescale 1ns/10ps
module cable_model
  import cdiag_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic meas_start,
  input wire logic stray,
  input wire logic [7:0] delay,
  input wire result_set_t flags,
  output logic meas_done,
  output result_set_t meas_flags
);
  logic busy_m;
  logic [7:0] cnt;
  // Flags toggle every cycle outside the done cycle, so stale values are never trusted.
  // The line is measured when asked, or once on a stray pulse.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_m <= 1'b0;
      cnt <= 8'h00;
      meas_done <= 1'b0;
      meas_flags <= '0;
    end
    else
    begin
      meas_done <= 1'b0;
      meas_flags <= ~meas_flags;
      if (meas_start)
      begin
        busy_m <= 1'b1;
        cnt <= delay;
      end
      else if (busy_m && cnt == 8'h00)
      begin
        busy_m <= 1'b0;
        meas_done <= 1'b1;
        meas_flags <= flags;
      end
      else if (busy_m)
        cnt <= cnt - 8'h01;
      else if (stray)
      begin
        meas_done <= 1'b1;
        meas_flags <= flags;
      end
    end
  end
endmodule

// ---- verif/cable_diag_result_regs_bench.sv ----
// Self-checking bench of the cable diagnostic result register bank.
// Assumes the cable model on the front-end side and an AXI4-Lite master here.
`timescale 1ns/10ps
module cable_diag_result_regs_bench;
  import cdiag_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic stray = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  logic awready, wready, bvalid, arready, rvalid, meas_start, meas_done, irq;
  logic [1:0] bresp, rresp;
  logic [7:0] delay = 8'h28;
  result_set_t flags = '0, meas_flags, last;
  logic [15:0] seed = 16'h002B;
  logic [33:0] q[$];
  logic [IDX_W-1:0] rst_idx [7] = '{IDX_RUN, IDX_XPAIR, IDX_RESULT0, IDX_RESULT1,
    IDX_RESULT2, IDX_IRQ_STATUS, IDX_IRQ_MASK};
  int error_cnt = 0;
  int n_checks = 0;
  int starts = 0;

  cable_diag_result_regs i_cable_diag_result_regs (.MCLK(mclk), .RST_N(rst_n),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWPROT(3'h0), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .MEAS_START(meas_start), .MEAS_DONE(meas_done), .MEAS_FLAGS(meas_flags), .IRQ(irq));

  cable_model i_cable_model (.clk(mclk), .rst_n(rst_n), .meas_start(meas_start),
    .stray(stray), .delay(delay), .flags(flags), .meas_done(meas_done),
    .meas_flags(meas_flags));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    n_checks++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One bus transfer; the expected answer is queued before the request goes out.
  task automatic xfer(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] d,
    input logic [33:0] want);
    logic a, w, r, e;
    int n;
    q.push_back(want);
    @(posedge mclk);
    awvalid <= wr;
    wvalid <= wr;
    bready <= wr;
    arvalid <= !wr;
    rready <= !wr;
    awaddr <= {idx, 2'h0};
    araddr <= {idx, 2'h0};
    wdata <= d;
    n = 0;
    do
    begin
      @(negedge mclk);
      a = awvalid && awready;
      w = wvalid && wready;
      r = arvalid && arready;
      e = (bvalid && bready) || (rvalid && rready);
      n++;
      @(posedge mclk);
      if (a)
        awvalid <= 1'b0;
      if (w)
        wvalid <= 1'b0;
      if (r)
        arvalid <= 1'b0;
    end
    while (!e && n < 100);
    bready <= 1'b0;
    rready <= 1'b0;
    check({33'h0, e}, 34'h1);
  endtask

  task automatic rd(input logic [IDX_W-1:0] idx, input logic [31:0] v);
    xfer(1'b0, idx, 32'h0, {RESP_OKAY, v});
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d, {RESP_OKAY, 32'h0});
  endtask

  task automatic irq_after(input logic want);
    repeat (2) @(negedge mclk);
    check({33'h0, irq}, {33'h0, want});
  endtask

  // One diagnostic run with given flags and cross-pair setting.
  task automatic run(input result_set_t f, input logic xoff);
    logic fault;
    int s0;
    int n;
    wr(IDX_XPAIR, {31'h7FFFFFFF, xoff});
    rd(IDX_XPAIR, {31'h0, xoff});
    fault = 1'b0;
    for (int p = 0; p < PAIRS; p++)
    begin
      last[p] = xoff ? (f[p] & ~CROSS_MASK) : f[p];
      fault = fault | (|(last[p] & FAULT_MASK));
    end
    flags <= f;
    delay <= 8'h28 + {3'h0, seed[4:0]};
    s0 = starts;
    wr(IDX_RUN, 32'h1);
    rd(IDX_RUN, 32'h1);
    rd(IDX_RESULT0, 32'h0);
    wr(IDX_XPAIR, {31'h0, !xoff});
    n = 0;
    while (irq !== 1'b1 && n < 300)
    begin
      @(negedge mclk);
      n++;
    end
    check({33'h0, irq}, 34'h1);
    check(34'(starts - s0), 34'h1);
    rd(IDX_RUN, 32'h0);
    for (int p = 0; p < PAIRS; p++)
      rd(IDX_W'(IDX_RESULT0 + p), {21'h0, last[p]});
    rd(IDX_IRQ_STATUS, {30'h0, fault, 1'b1});
    wr(IDX_IRQ_MASK, 32'h0);
    irq_after(1'b0);
    wr(IDX_IRQ_MASK, 32'h3);
    irq_after(1'b1);
    wr(IDX_IRQ_STATUS, 32'h3);
    irq_after(1'b0);
  endtask

  // ----------------------------------------------------------------------
  // Clock, monitor, watchdog and main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    forever #4 mclk = ~mclk;
  end

  always @(negedge mclk)
  begin
    if ((bvalid && bready) || (rvalid && rready))
      check(bvalid ? {bresp, 32'h0} : {rresp, rdata}, q.pop_front());
    if (meas_start)
      starts++;
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    finish_test();
  end

  initial
  begin
    result_set_t f;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (rst_idx[i])
      rd(rst_idx[i], 32'h0);
    xfer(1'b1, 16'hBA20, 32'hFFFFFFFF, {RESP_SLVERR, 32'h0});
    xfer(1'b0, 16'hBA20, 32'h0, {RESP_SLVERR, 32'h0});
    wr(IDX_RESULT1, 32'hFFFFFFFF);
    rd(IDX_RESULT1, 32'h0);
    wr(IDX_IRQ_MASK, 32'h3);
    for (int k = 0; k < 16; k++)
    begin
      for (int p = 0; p < PAIRS; p++)
      begin
        seed = lfsr(seed);
        f[p] = (k < WORD_W) ? (11'h001 << k) : seed[10:0];
      end
      run(f, (k >= WORD_W) && k[0]);
    end
    seed = lfsr(seed);
    flags <= {3{seed[10:0]}};
    @(posedge mclk);
    stray <= 1'b1;
    @(posedge mclk);
    stray <= 1'b0;
    for (int p = 0; p < PAIRS; p++)
      rd(IDX_W'(IDX_RESULT0 + p), {21'h0, last[p]});
    rd(IDX_IRQ_STATUS, 32'h0);
    finish_test();
  end
endmodule
